// ===== rtl/ssrc_pkg.sv
// constants and types shared by the stepper speed ramp control block
package ssrc_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_RAMP_UP = 6'h0d;
  localparam logic [5:0] IDX_RAMP_DN = 6'h0e;
  localparam logic [5:0] IDX_CW_LO = 6'h16;
  localparam logic [5:0] IDX_CW_HI = 6'h17;
  localparam logic [5:0] IDX_CCW_LO = 6'h18;
  localparam logic [5:0] IDX_CCW_HI = 6'h19;
  localparam logic [5:0] IDX_MOTOR = 6'h1a;
  localparam logic [5:0] IDX_STATUS = 6'h1b;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int RAMP_EN_BIT = 5;
  localparam int RAMP_REEN_BIT = 4;
  localparam int MC_RUN_BIT = 7;
  localparam int MC_ESTOP_BIT = 5;
  localparam int MC_DIR_BIT = 0;
  localparam int STAT_WIDTH_LSB = 16;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [5:0] RAMP_RST = 6'h00;
  localparam logic [15:0] PW_RST = 16'h0000;
  localparam logic MC_DIR_RST = 1'b0;

  // ------------------------------------------------------------------
  // ramp arithmetic
  // ------------------------------------------------------------------
  localparam logic [3:0] FACTOR_MAX = 4'hd;
  localparam logic [12:0] WIDTH_MAX = 13'h1fff;

  // ------------------------------------------------------------------
  // timing: smallest pulse step at prescaler code zero
  // ------------------------------------------------------------------
  localparam int UNIT_NS = 3000;
  localparam int CLK_NS = 25;
  localparam int BASE_CYC = (UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BASE_W = $clog2(BASE_CYC);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEL,
    ST_RUN,
    ST_DECEL
  } ssrc_state_t;

endpackage : ssrc_pkg

// ===== rtl/ssrc_tick_div.sv
// free running divider giving a one-cycle enable pulse
`timescale 1ns/100ps
module ssrc_tick_div #(
  parameter int DIV = 120,
  parameter int W = 7
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // enable pulse
  output logic tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // count to DIV-1 then wrap with a pulse
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + W'(1);
    if (cnt_r == W'(DIV - 1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : ssrc_tick_div

// ===== rtl/ssrc_ramp_ctrl.sv
// stepper speed ramp controller with avalon-mm register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ssrc_ramp_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [ssrc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ssrc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ssrc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // motor side
  output logic step_pulse,
  output logic motor_dir,
  output logic motor_busy
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic ack_r, ack_nxt, dir_r, dir_nxt, step_r, step_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] ru_r, ru_nxt, rd_r, rd_nxt;
  logic [15:0] cw_r, cw_nxt, ccw_r, ccw_nxt;
  ssrc_pkg::ssrc_state_t st_r, st_nxt;
  logic [12:0] cur_r, cur_nxt, wcnt_r, wcnt_nxt;
  logic [3:0] upf_r, upf_nxt, dnf_r, dnf_nxt;
  logic [6:0] pcnt_r, pcnt_nxt;
  logic base_tick, unit_tick, step_ev;
  logic wr_acc, wr_lo, start_cmd, stop_cmd, estop_cmd;
  logic [5:0] idx;
  logic [12:0] target;
  logic [2:0] presc;
  logic [6:0] pmask;
  logic [13:0] up_delta, dn_delta;
  logic [31:0] rmux;
  // clamp reserved factor codes to the largest legal one
  function automatic logic [3:0] fac_clamp(input logic [3:0] f);
    fac_clamp = (f > ssrc_pkg::FACTOR_MAX) ? ssrc_pkg::FACTOR_MAX : f;
  endfunction : fac_clamp

  // ------------------------------------------------------------------
  // time base
  // ------------------------------------------------------------------
  // 3 us base pulse from the core clock
  ssrc_tick_div #(
    .DIV(ssrc_pkg::BASE_CYC),
    .W(ssrc_pkg::BASE_W)
  ) u_base_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .tick(base_tick)
  );

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  // one wait state per access; the access completes when ack_r is high
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign idx = avs_address[7:2];
  assign wr_acc = avs_write & ack_r;
  assign wr_lo = wr_acc & avs_byteenable[0];
  assign start_cmd = wr_lo && idx == ssrc_pkg::IDX_MOTOR &&
                     avs_writedata[ssrc_pkg::MC_RUN_BIT];
  assign stop_cmd = wr_lo && idx == ssrc_pkg::IDX_MOTOR &&
                    !avs_writedata[ssrc_pkg::MC_RUN_BIT];
  assign estop_cmd = wr_lo && idx == ssrc_pkg::IDX_MOTOR &&
                     avs_writedata[ssrc_pkg::MC_ESTOP_BIT];

  // read multiplexer, unmapped words read zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (idx)
      ssrc_pkg::IDX_RAMP_UP: rmux = {26'h0, ru_r};
      ssrc_pkg::IDX_RAMP_DN: rmux = {26'h0, rd_r};
      ssrc_pkg::IDX_CW_LO: rmux = {24'h0, cw_r[7:0]};
      ssrc_pkg::IDX_CW_HI: rmux = {24'h0, cw_r[15:8]};
      ssrc_pkg::IDX_CCW_LO: rmux = {24'h0, ccw_r[7:0]};
      ssrc_pkg::IDX_CCW_HI: rmux = {24'h0, ccw_r[15:8]};
      ssrc_pkg::IDX_MOTOR: begin
        rmux[ssrc_pkg::MC_RUN_BIT] = st_r == ssrc_pkg::ST_ACCEL ||
                                     st_r == ssrc_pkg::ST_RUN;
        rmux[ssrc_pkg::MC_DIR_BIT] = dir_r;
      end
      ssrc_pkg::IDX_STATUS: begin
        rmux[0] = st_r != ssrc_pkg::ST_IDLE;
        rmux[1] = st_r == ssrc_pkg::ST_ACCEL;
        rmux[2] = st_r == ssrc_pkg::ST_RUN;
        rmux[3] = st_r == ssrc_pkg::ST_DECEL;
        rmux[ssrc_pkg::STAT_WIDTH_LSB +: 13] = cur_r;
      end
    endcase
  end

  // handshake and register writes
  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = (ack_nxt && avs_read) ? rmux : rdata_r;
    ru_nxt = ru_r;
    rd_nxt = rd_r;
    cw_nxt = cw_r;
    ccw_nxt = ccw_r;
    dir_nxt = dir_r;
    // re-enable bits drop one cycle after they were stored
    ru_nxt[ssrc_pkg::RAMP_REEN_BIT] = 1'b0;
    rd_nxt[ssrc_pkg::RAMP_REEN_BIT] = 1'b0;
    if (wr_lo) begin
      unique case (idx)
        ssrc_pkg::IDX_RAMP_UP: begin
          ru_nxt = avs_writedata[5:0];
          // re-enable only latches with the enable bit set
          ru_nxt[4] = avs_writedata[5] & avs_writedata[4];
        end
        ssrc_pkg::IDX_RAMP_DN: begin
          rd_nxt = avs_writedata[5:0];
          rd_nxt[4] = avs_writedata[5] & avs_writedata[4];
        end
        ssrc_pkg::IDX_CW_LO: cw_nxt[7:0] = avs_writedata[7:0];
        ssrc_pkg::IDX_CW_HI: cw_nxt[15:8] = avs_writedata[7:0];
        ssrc_pkg::IDX_CCW_LO: ccw_nxt[7:0] = avs_writedata[7:0];
        ssrc_pkg::IDX_CCW_HI: ccw_nxt[15:8] = avs_writedata[7:0];
        ssrc_pkg::IDX_MOTOR:
          dir_nxt = avs_writedata[ssrc_pkg::MC_DIR_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ru_r <= ssrc_pkg::RAMP_RST;
      rd_r <= ssrc_pkg::RAMP_RST;
      cw_r <= ssrc_pkg::PW_RST;
      ccw_r <= ssrc_pkg::PW_RST;
      dir_r <= ssrc_pkg::MC_DIR_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      ru_r <= ru_nxt;
      rd_r <= rd_nxt;
      cw_r <= cw_nxt;
      ccw_r <= ccw_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ------------------------------------------------------------------
  // step generator and ramp sequencer
  // ------------------------------------------------------------------
  // width and range of the active direction
  assign target = dir_r ? ccw_r[12:0] : cw_r[12:0];
  assign presc = dir_r ? ccw_r[15:13] : cw_r[15:13];
  assign pmask = 7'((8'h01 << presc) - 8'h01);
  assign unit_tick = base_tick && pcnt_r == pmask;
  assign step_ev = st_r != ssrc_pkg::ST_IDLE && unit_tick &&
                   wcnt_r == cur_r;
  assign up_delta = 14'h0001 << upf_r;
  assign dn_delta = 14'h0001 << dnf_r;

  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    upf_nxt = upf_r;
    dnf_nxt = dnf_r;
    step_nxt = step_ev;
    pcnt_nxt = pcnt_r;
    wcnt_nxt = wcnt_r;
    // prescaled unit tick and width counter
    if (st_r == ssrc_pkg::ST_IDLE) begin
      pcnt_nxt = 7'h00;
      wcnt_nxt = 13'h0000;
    end else if (base_tick) begin
      pcnt_nxt = unit_tick ? 7'h00 : pcnt_r + 7'h01;
      if (unit_tick) wcnt_nxt = step_ev ? 13'h0000 : wcnt_r + 13'h0001;
    end
    unique case (st_r)
      ssrc_pkg::ST_IDLE: begin
        if (start_cmd) begin
          if (ru_r[ssrc_pkg::RAMP_EN_BIT]) begin
            st_nxt = ssrc_pkg::ST_ACCEL;
            cur_nxt = ssrc_pkg::WIDTH_MAX;
            upf_nxt = fac_clamp(ru_r[3:0]);
          end else begin
            st_nxt = ssrc_pkg::ST_RUN;
            cur_nxt = target;
          end
        end
      end
      ssrc_pkg::ST_ACCEL: begin
        // ramp-up rate swap only while accelerating
        if (ru_r[ssrc_pkg::RAMP_REEN_BIT]) begin
          upf_nxt = fac_clamp(ru_r[3:0]);
        end
        if (step_ev) begin
          if ({2'b00, cur_r} <= {2'b00, target} + {1'b0, up_delta}) begin
            cur_nxt = target;
            st_nxt = ssrc_pkg::ST_RUN;
          end else begin
            cur_nxt = cur_r - up_delta[12:0];
          end
        end
      end
      ssrc_pkg::ST_RUN: cur_nxt = target;
      ssrc_pkg::ST_DECEL: begin
        if (rd_r[ssrc_pkg::RAMP_REEN_BIT]) begin
          dnf_nxt = fac_clamp(rd_r[3:0]);
        end
        if (step_ev) begin
          if ({2'b00, cur_r} + {1'b0, dn_delta} >=
              {2'b00, ssrc_pkg::WIDTH_MAX}) begin
            cur_nxt = ssrc_pkg::WIDTH_MAX;
            st_nxt = ssrc_pkg::ST_IDLE;
          end else begin
            cur_nxt = cur_r + dn_delta[12:0];
          end
        end
      end
    endcase
    // stop requests override the sequencer
    if (stop_cmd && (st_r == ssrc_pkg::ST_ACCEL ||
                     st_r == ssrc_pkg::ST_RUN)) begin
      if (rd_r[ssrc_pkg::RAMP_EN_BIT]) begin
        st_nxt = ssrc_pkg::ST_DECEL;
        dnf_nxt = fac_clamp(rd_r[3:0]);
      end else begin
        st_nxt = ssrc_pkg::ST_IDLE;
      end
    end
    if (estop_cmd) st_nxt = ssrc_pkg::ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ssrc_pkg::ST_IDLE;
      cur_r <= ssrc_pkg::WIDTH_MAX;
      upf_r <= 4'h0;
      dnf_r <= 4'h0;
      step_r <= 1'b0;
      pcnt_r <= 7'h00;
      wcnt_r <= 13'h0000;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      upf_r <= upf_nxt;
      dnf_r <= dnf_nxt;
      step_r <= step_nxt;
      pcnt_r <= pcnt_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  assign step_pulse = step_r;
  assign motor_dir = dir_r;
  assign motor_busy = st_r != ssrc_pkg::ST_IDLE;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_start_idle;
    start_cmd && !estop_cmd && st_r == ssrc_pkg::ST_IDLE;
  endsequence
  sequence s_up_reen_write;
    wr_lo && idx == ssrc_pkg::IDX_RAMP_UP && avs_writedata[5:4] == 2'b11;
  endsequence
  sequence s_accel_done;
    st_r == ssrc_pkg::ST_ACCEL ##1 st_r == ssrc_pkg::ST_RUN;
  endsequence
  a_accel_from_max: assert property (s_start_idle ##0 ru_r[5] |=>
    st_r == ssrc_pkg::ST_ACCEL && cur_r == ssrc_pkg::WIDTH_MAX)
    else $error("acceleration did not start at range maximum");
  a_plain_start: assert property (s_start_idle ##0 !ru_r[5] |=>
    st_r == ssrc_pkg::ST_RUN && cur_r == $past(target))
    else $error("start without ramp did not use target width");
  a_reen_self_clr: assert property (s_up_reen_write |=>
    ru_r[4] ##1 !ru_r[4])
    else $error("ramp-up re-enable bit did not self clear");
  a_up_rate_swap: assert property (ru_r[4] && ru_r[3:0] <= 4'hd &&
    st_r == ssrc_pkg::ST_ACCEL |=> upf_r == $past(ru_r[3:0]))
    else $error("new ramp-up factor not adopted");
  a_reen_gated: assert property (ru_r[4] && !start_cmd &&
    st_r != ssrc_pkg::ST_ACCEL |=> $stable(upf_r))
    else $error("ramp-up factor changed outside acceleration");
  a_dn_rate_swap: assert property (rd_r[4] && rd_r[3:0] <= 4'hd &&
    st_r == ssrc_pkg::ST_DECEL |=> dnf_r == $past(rd_r[3:0]))
    else $error("new ramp-down factor not adopted");
  a_accel_decr: assert property (st_r == ssrc_pkg::ST_ACCEL &&
    step_ev && !stop_cmd && !estop_cmd &&
    {2'b00, cur_r} > {2'b00, target} + {1'b0, up_delta} |=>
    cur_r == $past(cur_r) - $past(up_delta[12:0]))
    else $error("acceleration step size wrong");
  a_decel_incr: assert property (st_r == ssrc_pkg::ST_DECEL &&
    step_ev && !estop_cmd &&
    {2'b00, cur_r} + {1'b0, dn_delta} < 15'h1fff |=>
    cur_r == $past(cur_r) + $past(dn_delta[12:0]))
    else $error("deceleration step size wrong");
  a_accel_end: assert property (s_accel_done |->
    cur_r == $past(target))
    else $error("acceleration ended off target width");
  a_stop_ramp: assert property (stop_cmd && !estop_cmd && rd_r[5] &&
    st_r == ssrc_pkg::ST_RUN |=> st_r == ssrc_pkg::ST_DECEL ##1
    st_r == ssrc_pkg::ST_DECEL || st_r == ssrc_pkg::ST_IDLE)
    else $error("normal stop did not ramp down");
  a_estop_halt: assert property (estop_cmd |=>
    st_r == ssrc_pkg::ST_IDLE && !motor_busy)
    else $error("emergency stop did not halt");
  a_reserved_zero: assert property (avs_read && ack_r &&
    (idx == ssrc_pkg::IDX_RAMP_UP || idx == ssrc_pkg::IDX_RAMP_DN) |->
    avs_readdata[31:6] == 26'h0)
    else $error("reserved ramp bits read non-zero");

endmodule : ssrc_ramp_ctrl

// ===== testbench/ssrc_drv_model.sv
// behavioural coil driver stage: counts step pulses and their spacing
`timescale 1ns/100ps
module ssrc_drv_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // motor side of the block
  input wire logic step_pulse,
  input wire logic motor_dir,
  input wire logic motor_busy,
  // observed step figures
  output logic [31:0] n_steps,
  output logic [31:0] last_gap
);
  logic [31:0] gap_r;

  // spacing counter, latched at every completed step
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 32'h00000001;
      n_steps <= 32'h00000000;
      last_gap <= 32'h00000000;
    end else if (step_pulse) begin
      gap_r <= 32'h00000001;
      last_gap <= gap_r;
      n_steps <= n_steps + 32'h00000001;
    end else begin
      gap_r <= gap_r + 32'h00000001;
    end
  end
endmodule : ssrc_drv_model

// ===== testbench/test_stepper_speed_ramp_control.sv
// self-checking bench for the stepper speed ramp controller
`timescale 1ns/100ps
module test_stepper_speed_ramp_control;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int UNIT = 120;
  localparam logic [5:0] UP = ssrc_pkg::IDX_RAMP_UP;
  localparam logic [5:0] DN = ssrc_pkg::IDX_RAMP_DN;
  localparam logic [5:0] MC = ssrc_pkg::IDX_MOTOR;
  localparam logic [5:0] STA = ssrc_pkg::IDX_STATUS;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic step_pulse;
  logic motor_dir;
  logic motor_busy;
  logic [31:0] n_steps;
  logic [31:0] last_gap;
  logic [31:0] st;
  logic [7:0] dat;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t, w, d, f;

  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;

  ssrc_ramp_ctrl dut (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .step_pulse(step_pulse), .motor_dir(motor_dir),
    .motor_busy(motor_busy));

  ssrc_drv_model drv (.core_clk(core_clk), .resetn(resetn),
    .step_pulse(step_pulse), .motor_dir(motor_dir),
    .motor_busy(motor_busy), .n_steps(n_steps), .last_gap(last_gap));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // readback of a ramp control byte: reserved and re-enable bits clear
  function automatic logic [7:0] ramp_exp(input logic [7:0] v);
    return {2'b00, v[5], 1'b0, v[3:0]};
  endfunction : ramp_exp

  // spacing of steps for a width field and prescaler code
  function automatic logic [31:0] gap_exp(input int wd, input int pre);
    return 32'(((wd + 1) * UNIT) << pre);
  endfunction : gap_exp

  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one avalon access, held until waitrequest is seen low
  task bus(input logic wr, input logic [5:0] idx, input logic [7:0] v);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, v};
    // waitrequest and read data are both taken at the same rising edge
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    if (!wr) st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task steps(input int n);
    logic [31:0] goal;
    int k;
    goal = n_steps + 32'(n);
    k = 0;
    while (n_steps < goal && k < 60000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 60000) chk("step count", n_steps, goal);
  endtask : steps

  task idle_chk();
    repeat (2) @(negedge core_clk);
    chk("motor_busy", {31'h0, motor_busy}, 32'h0);
  endtask : idle_chk

  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    t = $urandom(32'hf1a0);
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, (i[0] ? UP : DN) + 6'(i[2:1] * 9), 8'h00);
      chk("reset value", st, 32'h0);
    end
    $display("reset values done");
    // factor codes, reserved bits and re-enable readback
    for (int r = 0; r < 2; r++) begin
      for (d = 0; d < 14; d++) begin
        dat = {2'b11, 2'($urandom_range(0, 3)), 4'(d)};
        bus(1'b1, r ? DN : UP, dat);
        bus(1'b0, r ? DN : UP, 8'h00);
        chk("ramp readback", st, {24'h0, ramp_exp(dat)});
      end
      avs_byteenable <= 4'h0;
      bus(1'b1, r ? DN : UP, 8'h00);
      avs_byteenable <= 4'h1;
      bus(1'b0, r ? DN : UP, 8'h00);
      chk("masked write", st, {24'h0, ramp_exp(dat)});
    end
    bus(1'b1, 6'h00, 8'hff);
    bus(1'b0, 6'h00, 8'h00);
    chk("unmapped", st, 32'h0);
    $display("register access done");
    // start without ramps, prescaler codes 0 to 2, either direction
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, UP, 8'h00);
      bus(1'b1, DN, 8'h00);
      t = $urandom_range(1, 6);
      w = $urandom_range(1, 6);
      d = $urandom_range(0, 1);
      bus(1'b1, ssrc_pkg::IDX_CW_LO, 8'(t));
      bus(1'b1, ssrc_pkg::IDX_CW_HI, {3'(p), 5'h00});
      bus(1'b1, ssrc_pkg::IDX_CCW_LO, 8'(w));
      bus(1'b1, ssrc_pkg::IDX_CCW_HI, {3'(p), 5'h00});
      bus(1'b1, MC, {7'h40, 1'(d)});
      if (d == 1) t = w;
      bus(1'b1, UP, 8'h31);
      bus(1'b0, STA, 8'h00);
      chk("run width", st, {3'h0, 13'(t), 12'h0, 4'h5});
      chk("direction", {31'h0, motor_dir}, 32'(d));
      chk("running busy", {31'h0, motor_busy}, 32'h1);
      bus(1'b0, MC, 8'h00);
      chk("motor readback", st, {24'h0, 7'h40, 1'(d)});
      steps(2);
      chk("step gap", last_gap, gap_exp(t, p));
      bus(1'b1, MC, 8'h00);
      idle_chk();
    end
    $display("plain start done");
    // accelerated start, rate change and emergency stop
    bus(1'b1, UP, 8'h25);
    bus(1'b1, DN, 8'h2d);
    bus(1'b1, MC, 8'h80);
    bus(1'b0, STA, 8'h00);
    chk("accel start", st, {3'h0, 13'h1fff, 12'h0, 4'h3});
    bus(1'b1, UP, 8'h33);
    bus(1'b0, UP, 8'h00);
    chk("up rate", st, 32'h23);
    bus(1'b0, STA, 8'h00);
    chk("accel kept", st, {3'h0, 13'h1fff, 12'h0, 4'h3});
    bus(1'b1, MC, 8'h20);
    idle_chk();
    $display("acceleration done");
    // deceleration, rate change on the fly, then a larger factor
    t = $urandom_range(1, 6);
    f = $urandom_range(1, 12);
    bus(1'b1, UP, 8'h00);
    bus(1'b1, DN, 8'h20);
    bus(1'b1, ssrc_pkg::IDX_CW_LO, 8'(t));
    bus(1'b1, ssrc_pkg::IDX_CW_HI, 8'h00);
    bus(1'b1, MC, 8'h80);
    steps(1);
    bus(1'b1, MC, 8'h00);
    bus(1'b0, STA, 8'h00);
    chk("decel start", st, {3'h0, 13'(t), 12'h0, 4'h9});
    steps(1);
    bus(1'b0, STA, 8'h00);
    chk("decel step", st[28:16], 32'(t + 1));
    bus(1'b1, DN, 8'h3d);
    bus(1'b0, DN, 8'h00);
    chk("down rate", st, 32'h2d);
    steps(1);
    chk("decel gap", last_gap, gap_exp(t + 1, 0));
    idle_chk();
    bus(1'b1, DN, 8'(32'h20 + f));
    bus(1'b1, MC, 8'h80);
    steps(1);
    bus(1'b1, MC, 8'h00);
    steps(1);
    bus(1'b0, STA, 8'h00);
    chk("factor step", st[28:16], 32'(t + (1 << f)));
    bus(1'b1, MC, 8'h20);
    idle_chk();
    $display("deceleration done");
    conclude();
  end
endmodule : test_stepper_speed_ramp_control
